//--- rtl/pebp_pkg.sv
// shared constants and types of the pipelined external bus master
package pebp_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_WD0 = 8'h10;
    localparam logic [7:0] OFS_RD0 = 8'h20;
    // configuration word layout
    localparam int CFG_DEPTH_B0 = 0;
    localparam int CFG_DEPTH_B1 = 2;
    localparam int CFG_DEPTH_HOST = 4;
    localparam int CFG_IDLE_LSB = 6;
    localparam int CFG_W64_MEM = 10;
    localparam int CFG_W64_HOST = 11;
    localparam int CFG_W64_MP = 12;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // command word layout
    localparam int CMD_TGT_LSB = 0;
    localparam int CMD_SIZE_LSB = 2;
    localparam int CMD_WR_BIT = 4;
    localparam int CMD_PEER_LSB = 5;
    // status word layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_INFLIGHT = 1;
    localparam int STAT_ILLEGAL = 2;
    localparam int STAT_CFG_LOCK = 3;
    // pipeline
    localparam logic [2:0] WR_DEPTH = 3'h1;
    localparam logic [2:0] PEER_DEPTH = 3'h4;
    localparam int SLOTS = 5;
    localparam logic [2:0] SINCE_MAX = 3'h7;

    typedef enum logic [1:0] {
        TGT_BANK0 = 2'b00,
        TGT_BANK1 = 2'b01,
        TGT_HOST = 2'b10,
        TGT_PEER = 2'b11
    } pebp_tgt_e;

    typedef enum logic [1:0] {
        SZ_SINGLE = 2'b00,
        SZ_LONG = 2'b01,
        SZ_QUAD = 2'b10
    } pebp_size_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ISSUE = 1'b1
    } pebp_st_e;

    typedef struct packed {
        logic wr;
        logic [1:0] beat;
        logic w64;
        logic sgl;
        logic hi;
        logic [63:0] data;
    } pebp_beat_s;

    typedef struct packed {
        logic v;
        pebp_beat_s b;
    } pebp_slot_s;
endpackage

//--- rtl/pebp_master.sv
// pipelined external bus master with apb registers and slave burst tracker
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
// ****************************************************************
// ****************************************************************
module pebp_master
    import pebp_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic [31:0] bus_addr, // address of current beat
    output logic rd_n, // read strobe
    output logic write_lower_half_n, // low word write strobe
    output logic write_upper_half_n, // high word write strobe
    output logic burst_continue_n, // next cycle same transfer
    output logic [63:0] bus_data_o, // write data
    output logic bus_data_oe, // write data drive enable
    input wire logic [63:0] bus_data_i, // read data
    input wire logic ack_i, // slave acknowledge
    input wire logic slv_addr_cycle, // address cycle aimed at us
    input wire logic slv_burst_continue_n, // burst continue seen as slave
    input wire logic slv_quad_only, // target accepts quad only
    output logic slv_txn_done, // inbound transfer closed
    output logic [2:0] slv_txn_beats, // its beat count
    output logic slv_illegal // unlinked quad-only access
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic tgt_w64(logic [31:0] c, pebp_tgt_e t);
        if (t == TGT_PEER)
            return c[CFG_W64_MP];
        else if (t == TGT_HOST)
            return c[CFG_W64_HOST];
        return c[CFG_W64_MEM];
    endfunction

    function automatic logic [2:0] depth_of(logic [31:0] c, pebp_tgt_e t, logic w);
        logic [1:0] code;
        case (t)
            TGT_BANK1: code = c[CFG_DEPTH_B1 +: 2];
            TGT_HOST: code = c[CFG_DEPTH_HOST +: 2];
            default: code = c[CFG_DEPTH_B0 +: 2];
        endcase
        if (w)
            return WR_DEPTH;
        else if (t == TGT_PEER)
            return PEER_DEPTH;
        return {1'b0, code} + 3'h1;
    endfunction

    function automatic logic [2:0] beats_of(logic [1:0] sz, logic w64);
        case (sz)
            SZ_LONG: return w64 ? 3'h1 : 3'h2;
            SZ_QUAD: return w64 ? 3'h2 : 3'h4;
            default: return 3'h1;
        endcase
    endfunction

    // ************************************************************
    // apb slave and registers
    // ************************************************************
    logic [31:0] cfg_q, addr_q, cmd_q, stat;
    logic [31:0] wdata_q [4];
    logic [31:0] rdata_q [4];
    logic cfg_lock_q, illegal_q, acc, hit, cmd_go, busy;
    pebp_st_e st_q;
    pebp_tgt_e cur_tgt, new_tgt;

    assign acc = psel & penable;
    assign hit = paddr[1:0] == 2'h0 && (paddr <= OFS_STAT
        || paddr[7:4] == OFS_WD0[7:4] || paddr[7:4] == OFS_RD0[7:4]);
    assign pready = 1'b1;
    // a command while the previous one is still issuing is refused
    assign pslverr = acc & (!hit | (pwrite & paddr == OFS_CMD & st_q != ST_IDLE));
    assign cmd_go = acc & pwrite & paddr == OFS_CMD & st_q == ST_IDLE;
    assign new_tgt = pebp_tgt_e'(pwdata[CMD_TGT_LSB +: 2]);

    always_comb
    begin
        stat = 32'h0;
        stat[STAT_BUSY] = busy;
        stat[STAT_INFLIGHT] = st_q == ST_ISSUE;
        stat[STAT_ILLEGAL] = illegal_q;
        stat[STAT_CFG_LOCK] = cfg_lock_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable)
        begin
            if (paddr == OFS_CFG)
                prdata <= cfg_q;
            else if (paddr == OFS_ADDR)
                prdata <= addr_q;
            else if (paddr == OFS_CMD)
                prdata <= cmd_q;
            else if (paddr == OFS_STAT)
                prdata <= stat;
            else if (hit && paddr[7:4] == OFS_WD0[7:4])
                prdata <= wdata_q[paddr[3:2]];
            else if (hit && paddr[7:4] == OFS_RD0[7:4])
                prdata <= rdata_q[paddr[3:2]];
            else
                prdata <= 32'h0;
        end
    end

    // configuration takes one write only, later writes are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= CFG_RESET;
            cfg_lock_q <= 1'b0;
            addr_q <= 32'h0;
            cmd_q <= 32'h0;
        end
        else if (acc && pwrite)
        begin
            if (paddr == OFS_CFG && !cfg_lock_q)
            begin
                cfg_q <= pwdata;
                cfg_lock_q <= 1'b1;
            end
            if (paddr == OFS_ADDR)
                addr_q <= pwdata;
            if (cmd_go)
                cmd_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdata_q <= '{default: 32'h0};
        else if (acc && pwrite && paddr[7:4] == OFS_WD0[7:4] && paddr[1:0] == 2'h0)
            wdata_q[paddr[3:2]] <= pwdata;
    end

    // a new illegal event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            illegal_q <= 1'b0;
        else if (slv_illegal)
            illegal_q <= 1'b1;
        else if (acc && pwrite && paddr == OFS_STAT && pwdata[STAT_ILLEGAL])
            illegal_q <= 1'b0;
    end

    // ************************************************************
    // issue sequencer and spacing
    // ************************************************************
    logic [2:0] beats_left_q, cur_depth, last_depth_q, since_q, gap, diff;
    logic [1:0] beat_idx_q, sel_lo, sel_hi;
    logic [31:0] baddr_q;
    logic cur_wr, cur_w64, cur_sgl, last_v_q, last_wr_q, same_zone, rr, idle_c;
    logic hold_q, load, shift, wait_now, ins;
    logic [3:0] elapsed;
    pebp_tgt_e last_tgt_q;
    logic [2:0] last_peer_q;
    pebp_beat_s next_ent, bus_ent_q;
    logic [2:0] bus_depth_q, ins_idx;
    logic bus_v_q;
    pebp_slot_s slot_q [SLOTS];

    assign cur_tgt = pebp_tgt_e'(cmd_q[CMD_TGT_LSB +: 2]);
    assign cur_wr = cmd_q[CMD_WR_BIT];
    assign cur_w64 = tgt_w64(cfg_q, cur_tgt);
    assign cur_sgl = cmd_q[CMD_SIZE_LSB +: 2] == SZ_SINGLE;
    assign cur_depth = depth_of(cfg_q, cur_tgt, cur_wr);

    assign same_zone = last_tgt_q == cur_tgt
        && (cur_tgt != TGT_PEER || last_peer_q == cmd_q[CMD_PEER_LSB +: 3]);
    assign rr = !last_wr_q & !cur_wr;
    assign idle_c = (rr & !same_zone & cur_depth <= last_depth_q)
        | (rr & same_zone & cfg_q[CFG_IDLE_LSB + int'(cur_tgt)])
        | ((last_wr_q != cur_wr) & cur_depth <= last_depth_q);
    assign diff = last_depth_q - cur_depth;
    always_comb
    begin
        if (!last_v_q)
            gap = 3'h0;
        else if (last_depth_q > cur_depth)
            gap = diff + {2'h0, idle_c | diff == 3'h1};
        else
            gap = {2'h0, idle_c};
    end

    assign elapsed = bus_v_q ? 4'h0 : {1'b0, since_q} + 4'h1;
    // later beats of one transfer skip the gap; the first waits out the gap; every beat stops while hold_q is set
    assign load = !hold_q && st_q == ST_ISSUE
        && (beat_idx_q != 2'h0 || elapsed >= {1'b0, gap});
    assign busy = st_q == ST_ISSUE || bus_v_q || slot_q[0].v || slot_q[1].v
        || slot_q[2].v || slot_q[3].v || slot_q[4].v;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= ST_IDLE;
            beats_left_q <= 3'h0;
            beat_idx_q <= 2'h0;
            baddr_q <= 32'h0;
        end
        else if (cmd_go)
        begin
            st_q <= ST_ISSUE;
            beats_left_q <= beats_of(pwdata[CMD_SIZE_LSB +: 2], tgt_w64(cfg_q, new_tgt));
            beat_idx_q <= 2'h0;
            baddr_q <= addr_q;
        end
        else if (load)
        begin
            beats_left_q <= beats_left_q - 3'h1;
            beat_idx_q <= beat_idx_q + 2'h1;
            baddr_q <= baddr_q + (cur_w64 ? 32'h2 : 32'h1);
            if (beats_left_q == 3'h1)
                st_q <= ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_v_q <= 1'b0;
            last_wr_q <= 1'b0;
            last_tgt_q <= TGT_BANK0;
            last_peer_q <= 3'h0;
            last_depth_q <= WR_DEPTH;
        end
        else if (load && beats_left_q == 3'h1)
        begin
            last_v_q <= 1'b1;
            last_wr_q <= cur_wr;
            last_tgt_q <= cur_tgt;
            last_peer_q <= cmd_q[CMD_PEER_LSB +: 3];
            last_depth_q <= cur_depth;
        end
    end

    // counts empty bus cycles since the last address cycle; frozen by waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_q <= SINCE_MAX;
        else if (!hold_q)
            since_q <= bus_v_q ? 3'h0 : (since_q == SINCE_MAX ? SINCE_MAX : since_q + 3'h1);
    end

    // ************************************************************
    // address cycle outputs
    // ************************************************************
    assign sel_lo = cur_w64 ? {beat_idx_q[0], 1'b0} : beat_idx_q;
    assign sel_hi = (cur_w64 & !cur_sgl) ? {beat_idx_q[0], 1'b1} : 2'h0;
    always_comb
    begin
        next_ent.wr = cur_wr;
        next_ent.beat = beat_idx_q;
        next_ent.w64 = cur_w64;
        next_ent.sgl = cur_sgl;
        next_ent.hi = cur_w64 & cur_sgl & baddr_q[0];
        next_ent.data = {cur_w64 ? wdata_q[sel_hi] : 32'h0, wdata_q[sel_lo]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_v_q <= 1'b0;
            rd_n <= 1'b1;
            write_lower_half_n <= 1'b1;
            write_upper_half_n <= 1'b1;
            burst_continue_n <= 1'b1;
            bus_addr <= 32'h0;
            bus_ent_q <= '0;
            bus_depth_q <= WR_DEPTH;
        end
        else if (!hold_q)
        begin
            bus_v_q <= load;
            rd_n <= !(load & !cur_wr);
            write_lower_half_n <= !(load & cur_wr & (!cur_w64 | !next_ent.hi));
            write_upper_half_n <= !(load & cur_wr & cur_w64 & !(cur_sgl & !baddr_q[0]));
            burst_continue_n <= !(load & beats_left_q > 3'h1);
            if (load)
            begin
                bus_addr <= baddr_q;
                bus_ent_q <= next_ent;
                bus_depth_q <= cur_depth;
            end
        end
    end

    // ************************************************************
    // outstanding data cycles
    // ************************************************************
    // idle ack is held high by the pull-up, so an empty slot 0 never waits
    assign wait_now = slot_q[0].v & !ack_i;
    assign shift = !wait_now;
    assign ins = bus_v_q & !hold_q;
    // an address taken while the pipe is frozen lands one slot further out
    assign ins_idx = shift ? bus_depth_q - 3'h1 : bus_depth_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_q <= 1'b0;
        else
            hold_q <= wait_now;
    end

    pebp_slot_s slot_d [SLOTS];
    logic [SLOTS-1:0] clash;
    for (genvar i = 0; i < SLOTS; i++)
    begin : g_slot
        pebp_slot_s up, nxt;
        logic cl;
        if (i == SLOTS - 1)
        begin : g_top
            assign up = '0;
        end
        else
        begin : g_mid
            assign up = slot_q[i + 1];
        end
        always_comb
        begin
            nxt = shift ? up : slot_q[i];
            cl = 1'b0;
            if (ins && ins_idx == 3'(i))
            begin
                cl = nxt.v;
                nxt.v = 1'b1;
                nxt.b = bus_ent_q;
            end
        end
        assign slot_d[i] = nxt;
        assign clash[i] = cl;
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                slot_q[i] <= '0;
            else
                slot_q[i] <= slot_d[i];
        end
    end

    // write data is driven only in write data cycles and held through waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_data_o <= 64'h0;
            bus_data_oe <= 1'b0;
        end
        else
        begin
            bus_data_oe <= slot_d[0].v & slot_d[0].b.wr;
            if (slot_d[0].v && slot_d[0].b.wr)
                bus_data_o <= slot_d[0].b.data;
        end
    end

    logic cap;
    logic [1:0] wl, wh;
    assign cap = slot_q[0].v & ack_i & !slot_q[0].b.wr;
    assign wl = slot_q[0].b.w64 ? {slot_q[0].b.beat[0] & !slot_q[0].b.sgl, 1'b0} : slot_q[0].b.beat;
    assign wh = {slot_q[0].b.beat[0], 1'b1};
    for (genvar w = 0; w < 4; w++)
    begin : g_rd
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                rdata_q[w] <= 32'h0;
            else if (cap && 2'(w) == wl)
                rdata_q[w] <= slot_q[0].b.hi ? bus_data_i[63:32] : bus_data_i[31:0];
            else if (cap && slot_q[0].b.w64 && !slot_q[0].b.sgl && 2'(w) == wh)
                rdata_q[w] <= bus_data_i[63:32];
        end
    end

    // ************************************************************
    // inbound burst tracking as a slave
    // ************************************************************
    logic ackl_q;
    logic [2:0] slv_cnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ackl_q <= 1'b0;
            slv_cnt_q <= 3'h0;
            slv_txn_done <= 1'b0;
            slv_txn_beats <= 3'h0;
            slv_illegal <= 1'b0;
        end
        else
        begin
            ackl_q <= !ack_i;
            slv_txn_done <= 1'b0;
            slv_illegal <= 1'b0;
            // a stretched address during a stall is the same beat, not a new one
            if (slv_addr_cycle && !ackl_q)
            begin
                if (slv_burst_continue_n)
                begin
                    slv_txn_done <= 1'b1;
                    slv_txn_beats <= slv_cnt_q + 3'h1;
                    slv_illegal <= slv_quad_only & slv_cnt_q == 3'h0;
                    slv_cnt_q <= 3'h0;
                end
                else if (slv_cnt_q != 3'h7)
                    slv_cnt_q <= slv_cnt_q + 3'h1;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait;
        slot_q[0].v && !ack_i;
    endsequence
    sequence s_wr_taken;
        ins && bus_ent_q.wr && shift;
    endsequence

    a_dir_strobes: assert property (bus_v_q |-> rd_n == !(write_lower_half_n & write_upper_half_n))
        else $error("read and write strobes disagree");
    a_half_narrow: assert property (!bus_v_q || bus_ent_q.w64 || write_upper_half_n)
        else $error("upper strobe on a 32-bit bus");
    a_burst_link: assert property (bus_v_q && !burst_continue_n && !hold_q |=> bus_v_q)
        else $error("burst continue without a following beat");
    a_write_depth: assert property (s_wr_taken |=> slot_q[0].v && slot_q[0].b.wr && bus_data_oe)
        else $error("write data not one cycle after address");
    a_peer_depth: assert property (st_q == ST_ISSUE && cur_tgt == TGT_PEER && !cur_wr |-> cur_depth == 3'h4)
        else $error("peer read depth is not four");
    a_code_depth: assert property (st_q == ST_ISSUE && !cur_wr && cur_tgt == TGT_BANK1
        |-> cur_depth == {1'b0, cfg_q[CFG_DEPTH_B1 +: 2]} + 3'h1)
        else $error("bank depth does not follow its code");
    a_quad_beats: assert property (cmd_go && pwdata[CMD_SIZE_LSB +: 2] == SZ_QUAD
        && !tgt_w64(cfg_q, new_tgt) |=> beats_left_q == 3'h4)
        else $error("quad on 32-bit bus is not four beats");
    // the address issued in the ack-low cycle itself still moves; the one after it is frozen
    a_stall_hold: assert property (s_wait |=> hold_q && $stable(slot_q[0]) ##1 $stable(bus_addr))
        else $error("pipeline moved during a wait");
    a_no_clash: assert property (clash == '0)
        else $error("two data cycles collided");
    a_slave_lone: assert property (slv_addr_cycle && !ackl_q && slv_burst_continue_n && slv_quad_only
        && slv_cnt_q == 3'h0 |=> slv_illegal && slv_txn_done)
        else $error("lone quad-only beat not flagged");
endmodule

//--- testbench/pebp_slave_model.sv
// pipelined read slave model with programmable wait cycles
`timescale 1ns/100ps
// ****
// slave model
// ****
module pebp_slave_model
(
    input wire logic pclk, // system clock
    input wire logic [1:0] waits, // wait cycles on a read data cycle
    input wire logic rd_n, // read strobe
    input wire logic [31:0] bus_addr, // beat address
    output logic ack_i, // acknowledge
    output logic [63:0] bus_data_i // read data
);
    logic [31:0] a_q [5];
    logic [4:0] v_q = 5'h00;
    logic [1:0] w_q = 2'h0;
    logic ackp_q = 1'b1;
    logic [63:0] dl_q = 64'h0;
    logic [2:0] ix;
    // depth code sits in address bits 29:28, decoded as a real slave would
    assign ix = {1'b0, bus_addr[29:28]} + {2'b0, !ack_i};
    assign ack_i = !(v_q[0] && w_q != 2'h0);
    // released data bus shows the inverse of the last value, never a stale copy
    assign bus_data_i = (v_q[0] && ack_i) ? {~a_q[0], a_q[0]} : ~dl_q;
    always @(posedge pclk)
    begin
        ackp_q <= ack_i;
        dl_q <= bus_data_i;
        if (ack_i)
        begin
            v_q <= {1'b0, v_q[4:1]};
            for (int k = 0; k < 4; k++)
                a_q[k] <= a_q[k + 1];
        end
        // a stretched repeat of an address is not a new beat
        if (!rd_n && ackp_q)
        begin
            v_q[ix] <= 1'b1;
            a_q[ix] <= bus_addr;
        end
        if (!v_q[0])
            w_q <= waits;
        else if (w_q != 2'h0)
            w_q <= w_q - 2'h1;
    end
endmodule

//--- testbench/pipelined_external_bus_protocol_bench.sv
// self-checking bench for the pipelined external bus master
`timescale 1ns/100ps
// ****
// bench
// ****
module pipelined_external_bus_protocol_bench;
    import pebp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, bus_addr, q;
    logic pready, pslverr, rd_n, wl_n, wh_n, bc_n, oe, ack_i, done, ill, ackp = 1'b1;
    logic s_ac = 1'b0, s_bc_n = 1'b1, s_qo = 1'b0;
    logic [2:0] beats, sb;
    logic [1:0] waits = 2'h0;
    logic [63:0] wdo, rdi;
    int fail_count = 0, checks_done = 0, cyc = 0, nill = 0, nbc, nwh, nwr;
    int ac[$], dc[$];
    logic [63:0] wq[$];
    logic [31:0] ra[4] = '{32'h3000_0200, 32'h1000_0300, 32'h3000_0400, 32'h0000_0500};
    logic [31:0] rc[4] = '{32'h01, 32'h04, 32'h03, 32'h0A};
    int rb[4] = '{1, 2, 1, 4};
    pebp_master i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_addr(bus_addr), .rd_n(rd_n), .write_lower_half_n(wl_n), .write_upper_half_n(wh_n),
        .burst_continue_n(bc_n), .bus_data_o(wdo), .bus_data_oe(oe), .bus_data_i(rdi), .ack_i(ack_i),
        .slv_addr_cycle(s_ac), .slv_burst_continue_n(s_bc_n), .slv_quad_only(s_qo),
        .slv_txn_done(done), .slv_txn_beats(beats), .slv_illegal(ill));
    pebp_slave_model i_slv (.pclk(pclk), .waits(waits), .rd_n(rd_n), .bus_addr(bus_addr),
        .ack_i(ack_i), .bus_data_i(rdi));
    initial
        forever #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        ackp <= ack_i;
        if ((!rd_n || !wl_n || !wh_n) && ackp)
        begin
            ac.push_back(cyc);
            nbc += !bc_n;
            nwh += !wh_n;
            nwr += !wl_n;
        end
        if (oe)
        begin
            dc.push_back(cyc);
            wq.push_back(wdo);
        end
        if (done)
            sb <= beats;
        if (ill)
            nill++;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bound(input int t, input int lim);
        if (t >= lim)
        begin
            fail_count++;
            close_out();
        end
    endtask
    // apb master: request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 20);
        bound(t, 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input string nm, input int b);
        int t;
        t = 0;
        do
        begin
            apb(1'b0, OFS_STAT, 32'h0);
            t++;
        end
        while (q[b] !== 1'b0 && t < 50);
        bound(t, 50);
        $display("test %s done", nm);
    endtask
    task automatic go(input logic [31:0] a, input logic [31:0] c);
        ac.delete();
        dc.delete();
        wq.delete();
        nbc = 0;
        nwh = 0;
        nwr = 0;
        apb(1'b1, OFS_ADDR, a);
        apb(1'b1, OFS_CMD, c);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CFG, 32'h0);
        chk("cfg", q, CFG_RESET);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", err, 1'b1);
        apb(1'b1, OFS_CFG, 32'h0000_000D);
        for (int k = 0; k < 4; k++)
            apb(1'b1, OFS_WD0 + 8'(4 * k), 32'hA0 + k);
        go(32'h100, 32'h18);
        idle("quad write", STAT_BUSY);
        chk("beats", ac.size(), 4);
        chk("burst", nbc, 3);
        chk("upper", nwh, 0);
        for (int k = 0; k < 4; k++)
        begin
            chk("wdata", wq[k][31:0], 32'hA0 + k);
            chk("wdepth", dc[k] - ac[k], 1);
        end
        for (int w = 0; w < 3; w += 2)
            for (int i = 0; i < 4; i++)
            begin
                waits <= 2'(w);
                go(ra[i], rc[i]);
                idle("read", STAT_BUSY);
                chk("rbeats", ac.size(), rb[i]);
                chk("burst", nbc, rb[i] - 1);
                chk("dir", nwr + nwh, 0);
                for (int k = 0; k < rb[i]; k++)
                begin
                    apb(1'b0, OFS_RD0 + 8'(4 * k), 32'h0);
                    chk("rdata", q, ra[i] + k);
                end
            end
        waits <= 2'h0;
        go(32'h3000_0600, 32'h09);
        // next command follows at once, retried while the deep read still issues
        apb(1'b1, OFS_ADDR, 32'h1000_0700);
        for (int r = 0; r < 4; r++)
            if (r == 0 || err)
                apb(1'b1, OFS_CMD, 32'h00);
        idle("deep then shallow read", STAT_BUSY);
        chk("gap", ac[4] - ac[3], 4);
        apb(1'b0, OFS_RD0, 32'h0);
        chk("rdata", q, 32'h1000_0700);
        s_ac <= 1'b1;
        s_qo <= 1'b1;
        @(posedge pclk);
        s_ac <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("illegal", nill, 1);
        s_ac <= 1'b1;
        s_bc_n <= 1'b0;
        repeat (3) @(posedge pclk);
        s_bc_n <= 1'b1;
        @(posedge pclk);
        s_ac <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("sbeats", sb, 3'h4);
        chk("illegal", nill, 1);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("sticky", q[STAT_ILLEGAL], 1'b1);
        $display("test slave tracker done");
        // a second reset unlocks the configuration for a 64-bit memory bus
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, OFS_CFG, 32'h0000_0400);
        apb(1'b1, OFS_CFG, 32'h0000_0000);
        apb(1'b0, OFS_CFG, 32'h0);
        chk("cfg once", q, 32'h0000_0400);
        apb(1'b1, OFS_WD0, 32'hB0);
        apb(1'b1, OFS_WD0 + 8'h04, 32'hB1);
        go(32'h100, 32'h14);
        idle("wide write", STAT_BUSY);
        chk("wbeats", ac.size(), 1);
        chk("halves", nwr + nwh, 2);
        chk("wide", wq[0], {32'hB1, 32'hB0});
        chk("wburst", nbc, 0);
        close_out();
    end
endmodule
